// File: rudc_pkg.sv
package rudc_pkg;

    // ---------------------------------------------------------------
    // counter geometry
    // ---------------------------------------------------------------
    localparam int unsigned RUDC_STAGES = 3;
    localparam logic [RUDC_STAGES:0] RUDC_RADIX = 4'h8;
    localparam bit RUDC_BINARY = (RUDC_RADIX == (1 << RUDC_STAGES));

    typedef logic [RUDC_STAGES-1:0] rudc_count_t;

    // ---------------------------------------------------------------
    // count values
    // ---------------------------------------------------------------
    localparam rudc_count_t RUDC_ZERO = 3'h0;
    localparam rudc_count_t RUDC_ONE = 3'h1;
    localparam rudc_count_t RUDC_TWO = 3'h2;
    localparam rudc_count_t RUDC_THREE = 3'h3;
    localparam rudc_count_t RUDC_FOUR = 3'h4;
    localparam rudc_count_t RUDC_SIX = 3'h6;
    localparam rudc_count_t RUDC_ALL_ONES = 3'h7;
    localparam rudc_count_t RUDC_TOP = rudc_count_t'(RUDC_RADIX - 4'h1);

endpackage : rudc_pkg

// File: rudc_stage.sv
`timescale 1ns/10ps

module rudc_stage
    import rudc_pkg::*;
#(
    parameter bit COUNT_DOWN = 1'b0
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_load,
    input wire logic i_load_val,
    input wire logic i_toggle,
    output logic o_state,
    output logic o_state_next,
    output logic o_carry
);

    logic state_reg;
    logic state_next;
    logic carry_reg;
    logic carry_next;

    // ---------------------------------------------------------------
    // binary trigger with load
    // ---------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        carry_next = 1'b0;
        if (i_load) begin
            // load wins and swallows a coincident toggle
            state_next = i_load_val;
        end else if (i_toggle) begin
            state_next = ~state_reg;
            // up: carry on on-to-off, down: carry on off-to-on
            carry_next = COUNT_DOWN ? ~state_reg : state_reg; // [RULE3] [RULE8]
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= 1'b0;
            carry_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            carry_reg <= carry_next;
        end
    end

    assign o_state = state_reg;
    assign o_state_next = state_next;
    assign o_carry = carry_reg;

endmodule : rudc_stage

// File: rudc_counter.sv
`timescale 1ns/10ps

// Function
// [RULE1] clear drives every stage off before up counting starts
// [RULE2] strobe toggles only stage zero; higher stages move only by carry
// [RULE3] up counting carries to next stage only on an on-to-off change
// [RULE4] stage weights are one, two, four; on stages hold the pulse total
// [RULE5] three-stage up counter returns to zero on the eighth pulse
// [RULE6] non-binary radix wraps by blocking the strobe and forcing the wrap value
// [RULE7] down counting starts from a preset; each pulse subtracts one
// [RULE8] down counting carries to next stage only on an off-to-on change
// [RULE9] preset of three reaches zero after three pulses via two and one
// [RULE10] zero flag is high whenever every stage is off
// [RULE11] up wrap from all ones clears stages one by one, low to high
// [RULE12] down wrap from zero sets stages one by one, reaching the maximum
// [RULE13] source sends one-cycle strobes with an idle cycle between them
// [RULE14] clear and preset act on the edge and beat a coincident strobe

module rudc_counter
    import rudc_pkg::*;
#(
    parameter bit COUNT_DOWN = 1'b0
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_clear,
    input wire logic i_preset,
    input wire rudc_count_t i_preset_val,
    input wire logic i_strobe,
    output rudc_count_t o_count,
    output logic o_zero,
    output logic o_busy
);

    // ---------------------------------------------------------------
    // stage chain
    // ---------------------------------------------------------------
    rudc_count_t stage_q;
    rudc_count_t stage_next;
    rudc_count_t carry_q;
    rudc_count_t toggle;
    rudc_count_t load_val;
    logic load_all;
    logic wrap_block;
    logic busy;

    assign busy = |carry_q;

    // feedback for a radix that is not a power of two; the wrap value
    // is only judged once the chain has settled, so strobes must not
    // arrive while a ripple is still running in that mode
    always_comb begin
        wrap_block = 1'b0;
        if (!RUDC_BINARY && i_strobe && !busy) begin
            if (COUNT_DOWN) begin
                wrap_block = (stage_q == RUDC_ZERO); // [RULE6]
            end else begin
                wrap_block = (stage_q == RUDC_TOP); // [RULE6]
            end
        end
    end

    always_comb begin
        load_all = i_clear | i_preset | wrap_block;
        if (i_clear) begin
            load_val = RUDC_ZERO; // [RULE1] [RULE14]
        end else if (i_preset) begin
            load_val = i_preset_val; // [RULE7] [RULE14]
        end else if (COUNT_DOWN) begin
            load_val = RUDC_TOP; // [RULE6]
        end else begin
            load_val = RUDC_ZERO; // [RULE6]
        end
    end

    // the strobe reaches stage zero alone; each higher stage hears only
    // the carry of the stage below, so a ripple costs one cycle per stage
    genvar gi;
    generate
        for (gi = 0; gi < RUDC_STAGES; gi++) begin : g_stage
            if (gi == 0) begin : g_lsb
                // single-cycle strobes assumed; a held level would recount
                assign toggle[gi] = i_strobe & ~load_all; // [RULE2] [RULE13]
            end else begin : g_upper
                assign toggle[gi] = carry_q[gi-1]; // [RULE2] [RULE11] [RULE12]
            end
            rudc_stage #(
                .COUNT_DOWN(COUNT_DOWN)
            ) u_stage (
                .i_ref_clk(i_ref_clk),
                .i_rst(i_rst),
                .i_load(load_all),
                .i_load_val(load_val[gi]),
                .i_toggle(toggle[gi]),
                .o_state(stage_q[gi]),
                .o_state_next(stage_next[gi]),
                .o_carry(carry_q[gi])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // zero detect
    // ---------------------------------------------------------------
    logic zero_reg;
    logic zero_next;

    always_comb begin
        zero_next = (stage_next == RUDC_ZERO); // [RULE10]
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            zero_reg <= 1'b1;
        end else begin
            zero_reg <= zero_next;
        end
    end

    // stage bits weigh one, two, four by position
    assign o_count = stage_q; // [RULE4]
    assign o_zero = zero_reg;
    assign o_busy = busy;

    // ---------------------------------------------------------------
    // settled-value model, read only by the checks below
    // ---------------------------------------------------------------
    rudc_count_t model_reg;
    rudc_count_t model_next;

    always_comb begin
        model_next = model_reg;
        if (i_clear) begin
            model_next = RUDC_ZERO;
        end else if (i_preset) begin
            model_next = i_preset_val;
        end else if (i_strobe) begin
            if (COUNT_DOWN) begin
                if (model_reg == RUDC_ZERO) begin
                    model_next = RUDC_TOP;
                end else begin
                    model_next = rudc_count_t'(model_reg - RUDC_ONE);
                end
            end else begin
                if (model_reg == RUDC_TOP) begin
                    model_next = RUDC_ZERO;
                end else begin
                    model_next = rudc_count_t'(model_reg + RUDC_ONE);
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            model_reg <= RUDC_ZERO;
        end else begin
            model_reg <= model_next;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence seq_step;
        i_strobe && !i_clear && !i_preset && !busy;
    endsequence

    sequence seq_quiet2;
        (!i_strobe && !i_clear && !i_preset)[*2];
    endsequence

    sequence seq_quiet3;
        (!i_strobe && !i_clear && !i_preset)[*3];
    endsequence

    clear_to_zero_a: assert property ( // [RULE1]
        @(posedge i_ref_clk) disable iff (i_rst)
        i_clear |=> (o_count == RUDC_ZERO) && o_zero
    ) else $error("clear did not empty the counter");

    lsb_toggle_a: assert property ( // [RULE2]
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_strobe && !load_all) |=> (stage_q[0] != $past(stage_q[0]))
    ) else $error("strobe did not toggle stage zero");

    upper_by_carry_a: assert property ( // [RULE2]
        @(posedge i_ref_clk) disable iff (i_rst)
        ($changed(stage_q[1]) && !$past(load_all)) |-> $past(carry_q[0])
    ) else $error("stage one moved without a carry");

    settled_value_a: assert property ( // [RULE4] [RULE7]
        @(posedge i_ref_clk) disable iff (i_rst)
        !busy |-> (o_count == model_reg)
    ) else $error("settled count differs from pulse total");

    zero_flag_a: assert property ( // [RULE10]
        @(posedge i_ref_clk) disable iff (i_rst)
        o_zero == (o_count == RUDC_ZERO)
    ) else $error("zero flag disagrees with stages");

    preset_wins_a: assert property ( // [RULE14]
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_preset && !i_clear && i_strobe) |=> (o_count == $past(i_preset_val))
    ) else $error("strobe disturbed a preset");

    // ---------------------------------------------------------------
    // settling and hold
    // ---------------------------------------------------------------
    // top carry flop adds one busy cycle after a full-length ripple
    ripple_settle_a: assert property ( // [RULE11] [RULE12]
        @(posedge i_ref_clk) disable iff (i_rst)
        seq_step ##1 seq_quiet3 |=> !busy
    ) else $error("ripple did not settle in time");

    count_hold_a: assert property ( // [RULE2]
        @(posedge i_ref_clk) disable iff (i_rst)
        (!i_strobe && !i_clear && !i_preset && !busy) |=> $stable(o_count)
    ) else $error("idle counter changed");

    load_kills_carry_a: assert property ( // [RULE14]
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_clear || i_preset) |=> !busy
    ) else $error("load left a carry pending");

    preset_load_a: assert property ( // [RULE7]
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_preset && !i_clear) |=> (o_count == $past(i_preset_val))
    ) else $error("preset value not loaded");

    generate
        if (!COUNT_DOWN) begin : g_up_checks
            sequence seq_up_tail;
                (o_count == RUDC_FOUR) ##1 (o_count == RUDC_ZERO);
            endsequence

            up_carry_edge_a: assert property ( // [RULE3]
                @(posedge i_ref_clk) disable iff (i_rst)
                carry_q[0] |-> $fell(stage_q[0])
            ) else $error("up carry not on an on-to-off change");

            up_mid_carry_a: assert property ( // [RULE3]
                @(posedge i_ref_clk) disable iff (i_rst)
                carry_q[1] |-> $fell(stage_q[1])
            ) else $error("stage one carry not on an on-to-off change");

            if (RUDC_BINARY) begin : g_bin
                wrap_eight_a: assert property ( // [RULE5]
                    @(posedge i_ref_clk) disable iff (i_rst)
                    ((o_count == RUDC_ALL_ONES) and seq_step) ##1 seq_quiet2
                        |=> (o_count == RUDC_ZERO) && o_zero
                ) else $error("counter did not wrap to zero");

                up_ripple_a: assert property ( // [RULE11]
                    @(posedge i_ref_clk) disable iff (i_rst)
                    ((o_count == RUDC_ALL_ONES) and seq_step) ##1 seq_quiet2
                        |-> ($past(o_count) == RUDC_SIX) ##0 seq_up_tail
                ) else $error("up ripple order wrong");

                up_plain_step_a: assert property ( // [RULE3]
                    @(posedge i_ref_clk) disable iff (i_rst)
                    (seq_step and (o_count[0] == 1'b0))
                        |=> (o_count == rudc_count_t'($past(o_count) + RUDC_ONE)) && !busy
                ) else $error("off-to-on change disturbed the next stage");
            end
        end else begin : g_down_checks
            sequence seq_down_tail;
                (o_count == RUDC_THREE) ##1 (o_count == RUDC_ALL_ONES);
            endsequence

            down_carry_edge_a: assert property ( // [RULE8]
                @(posedge i_ref_clk) disable iff (i_rst)
                carry_q[0] |-> $rose(stage_q[0])
            ) else $error("down carry not on an off-to-on change");

            down_mid_carry_a: assert property ( // [RULE8]
                @(posedge i_ref_clk) disable iff (i_rst)
                carry_q[1] |-> $rose(stage_q[1])
            ) else $error("stage one carry not on an off-to-on change");

            down_from_three_a: assert property ( // [RULE9]
                @(posedge i_ref_clk) disable iff (i_rst)
                ((o_count == RUDC_THREE) and seq_step) |=> ##[0:3] (o_count == RUDC_TWO)
            ) else $error("three did not step to two");

            down_to_zero_a: assert property ( // [RULE9]
                @(posedge i_ref_clk) disable iff (i_rst)
                ((o_count == RUDC_ONE) and seq_step) |=> o_zero && !busy
            ) else $error("one did not step straight to zero");

            if (RUDC_BINARY) begin : g_bin
                down_ripple_a: assert property ( // [RULE12]
                    @(posedge i_ref_clk) disable iff (i_rst)
                    ((o_count == RUDC_ZERO) and seq_step) ##1 seq_quiet2
                        |-> ($past(o_count) == RUDC_ONE) ##0 seq_down_tail
                ) else $error("down ripple order wrong");

                down_plain_step_a: assert property ( // [RULE8]
                    @(posedge i_ref_clk) disable iff (i_rst)
                    (seq_step and (o_count[0] == 1'b1))
                        |=> (o_count == rudc_count_t'($past(o_count) - RUDC_ONE)) && !busy
                ) else $error("on-to-off change disturbed the next stage");
            end
        end
    endgenerate

endmodule : rudc_counter

// File: rudc_pulse_src.sv
`timescale 1ns/10ps

module rudc_pulse_src (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_fire,
    output logic o_strobe
);

    // ---------------------------------------------------------------
    // strobe shaping
    // ---------------------------------------------------------------
    // a held request yields a pulse every other cycle, each followed by an idle cycle
    logic strobe_reg;
    logic strobe_next;

    always_comb begin
        strobe_next = i_fire & ~strobe_reg;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            strobe_reg <= 1'b0;
        end else begin
            strobe_reg <= strobe_next;
        end
    end

    assign o_strobe = strobe_reg;

endmodule : rudc_pulse_src

// File: tb.sv
`timescale 1ns/10ps

module tb;
    import rudc_pkg::*;

    // ---------------------------------------------------------------
    // stimulus and observed signals
    // ---------------------------------------------------------------
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic clear = 1'b0;
    logic preset = 1'b0;
    logic fire = 1'b0;
    rudc_count_t pv_up = RUDC_ZERO;
    rudc_count_t pv_dn = RUDC_ZERO;
    logic strobe;
    rudc_count_t cnt_up;
    rudc_count_t cnt_dn;
    logic zero_up;
    logic zero_dn;
    logic busy_up;
    logic busy_dn;
    logic [4:0] st_up;
    logic [4:0] st_dn;
    int n_fail = 0;
    int n_compared = 0;

    always #50 i_ref_clk = ~i_ref_clk;

    assign st_up = {busy_up, zero_up, cnt_up};
    assign st_dn = {busy_dn, zero_dn, cnt_dn};

    rudc_pulse_src i_rudc_pulse_src (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_fire(fire),
        .o_strobe(strobe));
    rudc_counter #(.COUNT_DOWN(1'b0)) i_rudc_counter (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_clear(clear), .i_preset(preset), .i_preset_val(pv_up), .i_strobe(strobe),
        .o_count(cnt_up), .o_zero(zero_up), .o_busy(busy_up));
    // second instance needs its own name, so the direction is appended
    rudc_counter #(.COUNT_DOWN(1'b1)) i_rudc_counter_dn (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_clear(clear), .i_preset(preset), .i_preset_val(pv_dn), .i_strobe(strobe),
        .o_count(cnt_dn), .o_zero(zero_dn), .o_busy(busy_dn));

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    function automatic logic [4:0] ex(input logic b, input rudc_count_t c);
        return {b, (c === RUDC_ZERO), c};
    endfunction : ex

    task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    // request reaches the counter two edges later; returns half a cycle after
    task automatic pulse();
        @(posedge i_ref_clk) fire <= 1'b1;
        @(posedge i_ref_clk) fire <= 1'b0;
        @(posedge i_ref_clk);
        @(negedge i_ref_clk);
    endtask : pulse

    task automatic load(input rudc_count_t a, input rudc_count_t b);
        @(posedge i_ref_clk);
        preset <= 1'b1;
        pv_up <= a;
        pv_dn <= b;
        @(posedge i_ref_clk) preset <= 1'b0;
        @(negedge i_ref_clk);
        chk(st_up, ex(1'b0, a));
        chk(st_dn, ex(1'b0, b));
    endtask : load

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        chk(st_up, ex(1'b0, RUDC_ZERO));
        chk(st_dn, ex(1'b0, RUDC_ZERO));
    endtask : t_reset

    // nine pulses: up wraps past eight, down wraps below zero
    task automatic t_count();
        load(RUDC_ZERO, RUDC_ZERO);
        for (int k = 1; k <= 9; k++) begin
            pulse();
            repeat (3) @(negedge i_ref_clk);
            chk(st_up, ex(1'b0, rudc_count_t'(k)));
            chk(st_dn, ex(1'b0, rudc_count_t'(0 - k)));
        end
    endtask : t_count

    task automatic t_ripple();
        load(RUDC_ALL_ONES, RUDC_ZERO);
        pulse();
        chk(st_up, ex(1'b1, RUDC_SIX));
        chk(st_dn, ex(1'b1, RUDC_ONE));
        @(negedge i_ref_clk);
        chk(st_up, ex(1'b1, RUDC_FOUR));
        chk(st_dn, ex(1'b1, RUDC_THREE));
        @(negedge i_ref_clk);
        // the top stage carry keeps busy up one more cycle
        chk(st_up, ex(1'b1, RUDC_ZERO));
        chk(st_dn, ex(1'b1, RUDC_ALL_ONES));
        @(negedge i_ref_clk);
        chk(st_up, ex(1'b0, RUDC_ZERO));
        chk(st_dn, ex(1'b0, RUDC_ALL_ONES));
    endtask : t_ripple

    task automatic t_down3();
        load(RUDC_ZERO, RUDC_THREE);
        for (int k = 2; k >= 0; k--) begin
            pulse();
            repeat (3) @(negedge i_ref_clk);
            chk(st_dn, ex(1'b0, rudc_count_t'(k)));
        end
    endtask : t_down3

    // clear or preset lands on the same edge as a strobe
    task automatic t_prio(input logic c, input rudc_count_t v);
        load(3'h5, 3'h5);
        @(posedge i_ref_clk) fire <= 1'b1;
        @(posedge i_ref_clk);
        fire <= 1'b0;
        clear <= c;
        preset <= ~c;
        pv_up <= v;
        pv_dn <= v;
        @(posedge i_ref_clk);
        clear <= 1'b0;
        preset <= 1'b0;
        repeat (4) @(negedge i_ref_clk);
        chk(st_up, ex(1'b0, c ? RUDC_ZERO : v));
        chk(st_dn, ex(1'b0, c ? RUDC_ZERO : v));
    endtask : t_prio

    // ---------------------------------------------------------------
    // main sequence and hang guard
    // ---------------------------------------------------------------
    initial begin
        repeat (12) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(negedge i_ref_clk);
        t_reset();
        t_count();
        t_ripple();
        t_down3();
        t_prio(1'b1, RUDC_TWO);
        t_prio(1'b0, RUDC_TWO);
        test_done();
    end

    initial begin
        repeat (3000) @(posedge i_ref_clk);
        n_fail++;
        test_done();
    end

endmodule : tb
